//--- design/wdm_pkg.sv
// Purpose: shared constants and types for the watchdog timer monitor
// Assumes: 125 MHz system clock, four clocks per machine cycle
// Notes: Summary of operation list below
// Summary of operation
// - free-running divider chain, selectable tap sets time-out
// - select 00/01/10/11 gives 2^17/2^20/2^23/2^26 clocks
// - time-out sets interrupt flag, control bit 3
// - reset enabled, no restart in 512 clocks: reset
// - reset lasts two machine cycles, sets cause bit 2
// - writing restart bit 0 clears count, self-clearing
// - interrupt needs flag, extended enable, global enable
// - flag cleared by software write or any reset
// - cause flag sticky; untouched while reset enable low
// - clearing reset enable bit 1 keeps divider counting
// - power reset disables; dog reset keeps enable, restarts
// - flag, enable, restart writes need timed access
// - flag still set each interval when both disabled
// - interrupt and reset paths enabled independently
// - interval select defaults to shortest time-out
package wdm_pkg;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_PER_MC = 4;
  localparam int unsigned RST_MC = 2;
  localparam int unsigned RST_CYCLES = RST_MC * CLK_PER_MC;
  localparam int unsigned GRACE_CYCLES = 512;

  // default tap exponents of the divider chain
  localparam int unsigned EXP_SEL0 = 17;
  localparam int unsigned EXP_SEL1 = 20;
  localparam int unsigned EXP_SEL2 = 23;
  localparam int unsigned EXP_SEL3 = 26;

  // byte addresses on the register bus
  localparam logic [3:0] ADDR_WDCTL = 4'h0;
  localparam logic [3:0] ADDR_CKCTL = 4'h4;
  localparam logic [3:0] ADDR_EIE = 4'h8;

  // field positions
  localparam int unsigned BIT_RESTART = 0;
  localparam int unsigned BIT_RST_EN = 1;
  localparam int unsigned BIT_CAUSE = 2;
  localparam int unsigned BIT_TOFLAG = 3;
  localparam int unsigned BIT_SEL_LO = 6;
  localparam int unsigned BIT_SEL_HI = 7;
  localparam int unsigned BIT_DOG_IE = 4;

  localparam logic [1:0] SEL_RESET = 2'h0;

  typedef struct packed {
    logic timeout_irq_flag;
    logic dog_reset_cause_flag;
    logic dog_reset_enable;
    logic dog_restart;
  } wdm_ctl_type;

  localparam wdm_ctl_type CTL_RESET = '{default: 1'b0};

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_GRACE = 3'h2,
    ST_RESET = 3'h4
  } wdm_state_type;

endpackage

//--- design/wdm_divider.sv
// Purpose: free-running divider chain of the watchdog
// Assumes: synchronous clear has priority over counting
// Notes: wraps silently; taps are decoded by the caller
`timescale 1ns/100ps
module wdm_divider #(
  parameter int unsigned WIDTH = 26
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  output logic [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] count_ff;
  wire logic [WIDTH-1:0] nxt_count = clear_i ? '0 : count_ff + {{(WIDTH-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count_o = count_ff;

endmodule // wdm_divider

//--- design/wdm_top.sv
// Purpose: watchdog timer monitor with Avalon-MM register slave
// Assumes: srst_i is the power-on / power-fail reset; core inputs share clk_i
// Notes: registers answer one cycle after the request is seen
`timescale 1ns/100ps
module wdm_top #(
  parameter int unsigned EXP0 = wdm_pkg::EXP_SEL0,
  parameter int unsigned EXP1 = wdm_pkg::EXP_SEL1,
  parameter int unsigned EXP2 = wdm_pkg::EXP_SEL2,
  parameter int unsigned EXP3 = wdm_pkg::EXP_SEL3
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic global_irq_enable_i,
  input wire logic ta_open_i,
  output logic irq_o,
  output logic dog_sys_rst_o
);

  localparam int unsigned CW = EXP3;

  // bus handshake
  logic ack_ff;
  logic [31:0] rdata_ff;
  wire logic req = avs_read_i | avs_write_i;
  wire logic wr_go = avs_write_i & ack_ff;
  wire logic lane0 = avs_byteenable_i[0];
  wire logic hit_wd = avs_address_i == wdm_pkg::ADDR_WDCTL;
  wire logic hit_ck = avs_address_i == wdm_pkg::ADDR_CKCTL;
  wire logic hit_ie = avs_address_i == wdm_pkg::ADDR_EIE;
  wire logic wr_wd = wr_go & lane0 & hit_wd;
  wire logic wr_ck = wr_go & lane0 & hit_ck;
  wire logic wr_ie = wr_go & lane0 & hit_ie;
  wire logic wr_prot = wr_wd & ta_open_i;
  wire logic [7:0] wb = avs_writedata_i[7:0];

  // registers
  wdm_pkg::wdm_ctl_type ctl_ff;
  logic [1:0] sel_ff;
  logic dog_ie_ff;
  wdm_pkg::wdm_state_type state_ff;
  logic [9:0] grace_ff;
  logic [3:0] rstcnt_ff;

  // divider and tap decode
  logic [CW-1:0] count;
  wire logic dog_rst_start;
  wire logic restart = ctl_ff.dog_restart | dog_rst_start;

  wdm_divider #(
    .WIDTH(CW)
  ) u_div (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clear_i(restart),
    .count_o(count)
  );

  wire logic [31:0] exp_sel = (sel_ff == 2'h0) ? EXP0 : (sel_ff == 2'h1) ? EXP1 :
                              (sel_ff == 2'h2) ? EXP2 : EXP3;
  wire logic [31:0] mask_w = (32'h1 << exp_sel) - 32'h1;
  wire logic [CW-1:0] tap_mask = mask_w[CW-1:0];
  wire logic timeout = ((count & tap_mask) == tap_mask) & ~restart;

  // grace window and reset pulse
  wire logic grace_end = (state_ff == wdm_pkg::ST_GRACE) && (grace_ff == 10'(wdm_pkg::GRACE_CYCLES - 1));
  assign dog_rst_start = grace_end & ctl_ff.dog_reset_enable;
  wire logic rst_end = (state_ff == wdm_pkg::ST_RESET) && (rstcnt_ff == 4'(wdm_pkg::RST_CYCLES - 1));

  wdm_pkg::wdm_state_type nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      wdm_pkg::ST_RUN: begin
        if (timeout) begin
          nxt_state = wdm_pkg::ST_GRACE;
        end
      end
      wdm_pkg::ST_GRACE: begin
        if (ctl_ff.dog_restart) begin
          nxt_state = wdm_pkg::ST_RUN;
        end else if (dog_rst_start) begin
          nxt_state = wdm_pkg::ST_RESET;
        end else if (grace_end) begin
          nxt_state = wdm_pkg::ST_RUN;
        end
      end
      wdm_pkg::ST_RESET: begin
        if (rst_end) begin
          nxt_state = wdm_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = wdm_pkg::ST_RUN;
      end
    endcase
  end

  wire logic [9:0] nxt_grace = (state_ff == wdm_pkg::ST_GRACE) ? grace_ff + 10'h1 : 10'h0;
  wire logic [3:0] nxt_rstcnt = (state_ff == wdm_pkg::ST_RESET) ? rstcnt_ff + 4'h1 : 4'h0;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff <= wdm_pkg::ST_RUN;
      grace_ff <= 10'h0;
      rstcnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      grace_ff <= nxt_grace;
      rstcnt_ff <= nxt_rstcnt;
    end
  end

  assign dog_sys_rst_o = state_ff == wdm_pkg::ST_RESET;
  wire logic in_dog_rst = dog_sys_rst_o;

  // control register next values; hardware set wins over software clear
  wire logic nxt_flag = timeout | (~in_dog_rst & ~dog_rst_start &
                        (wr_prot ? wb[wdm_pkg::BIT_TOFLAG] : ctl_ff.timeout_irq_flag));
  wire logic nxt_cause = dog_rst_start | (wr_wd ? (wb[wdm_pkg::BIT_CAUSE] & ctl_ff.dog_reset_cause_flag)
                         : ctl_ff.dog_reset_cause_flag);
  wire logic nxt_rst_en = wr_prot ? wb[wdm_pkg::BIT_RST_EN] : ctl_ff.dog_reset_enable;
  wire logic nxt_restart = wr_prot & wb[wdm_pkg::BIT_RESTART];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl_ff <= wdm_pkg::CTL_RESET;
      sel_ff <= wdm_pkg::SEL_RESET;
      dog_ie_ff <= 1'b0;
    end else begin
      ctl_ff.timeout_irq_flag <= nxt_flag;
      ctl_ff.dog_reset_cause_flag <= nxt_cause;
      ctl_ff.dog_reset_enable <= nxt_rst_en;
      ctl_ff.dog_restart <= nxt_restart;
      if (wr_ck) begin
        sel_ff <= wb[wdm_pkg::BIT_SEL_HI:wdm_pkg::BIT_SEL_LO];
      end
      if (wr_ie) begin
        dog_ie_ff <= wb[wdm_pkg::BIT_DOG_IE];
      end
    end
  end

  assign irq_o = ctl_ff.timeout_irq_flag & dog_ie_ff & global_irq_enable_i;

  // read mux; unmapped addresses read zero
  wire logic [7:0] rd_wd = {4'h0, ctl_ff.timeout_irq_flag, ctl_ff.dog_reset_cause_flag,
                            ctl_ff.dog_reset_enable, ctl_ff.dog_restart};
  wire logic [7:0] rd_ck = {sel_ff, 6'h00};
  wire logic [7:0] rd_ie = {3'h0, dog_ie_ff, 4'h0};
  wire logic [7:0] rd_sel = hit_wd ? rd_wd : hit_ck ? rd_ck : hit_ie ? rd_ie : 8'h00;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (avs_read_i & ~ack_ff) begin
        rdata_ff <= {24'h000000, rd_sel};
      end
    end
  end

  assign avs_waitrequest_o = req & ~ack_ff;
  assign avs_readdata_o = rdata_ff;

  // checks
  irq_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    irq_o == (ctl_ff.timeout_irq_flag & dog_ie_ff & global_irq_enable_i))
    else $error("interrupt output not gated by flag and enables");
  flag_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    timeout |=> ctl_ff.timeout_irq_flag)
    else $error("time-out did not set flag");
  restart_self_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ctl_ff.dog_restart |=> !ctl_ff.dog_restart && count == '0)
    else $error("restart bit did not clear or count not restarted");
  rst_width_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(dog_sys_rst_o) |-> dog_sys_rst_o [*8] ##1 !dog_sys_rst_o)
    else $error("watchdog reset not two machine cycles");
  cause_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(dog_sys_rst_o) |-> ctl_ff.dog_reset_cause_flag && ctl_ff.dog_reset_enable)
    else $error("cause flag or enable wrong at watchdog reset");
  no_rst_dis_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !ctl_ff.dog_reset_enable |=> !$rose(dog_sys_rst_o))
    else $error("reset issued while reset disabled");
  cause_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !ctl_ff.dog_reset_enable && !wr_wd |=> $stable(ctl_ff.dog_reset_cause_flag))
    else $error("cause flag changed while reset disabled");
  ta_guard_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_wd && !ta_open_i && !timeout |=> $stable(ctl_ff.dog_reset_enable) && !ctl_ff.dog_restart)
    else $error("protected write accepted without timed access");
  grace_len_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(dog_sys_rst_o) |-> $past(state_ff == wdm_pkg::ST_GRACE) && $past(grace_ff) == 10'h1FF)
    else $error("reset not 512 clocks after time-out");
  bus_wait_a: assert property (@(posedge clk_i) disable iff (srst_i)
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait request longer than one cycle");

endmodule // wdm_top

//--- testbench/wdm_core_model.sv
// Purpose: stand-in for the core reset logic that takes the watchdog reset
// Assumes: reset pulse is active high on the system clock
// Notes: counts pulses and keeps the width of the last one
`timescale 1ns/100ps
module wdm_core_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic dog_rst_i,
  output logic [7:0] rst_cnt_o,
  output logic [7:0] rst_len_o
);
  logic [7:0] run_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_ff <= 8'h00;
      rst_cnt_o <= 8'h00;
      rst_len_o <= 8'h00;
    end else begin
      run_ff <= dog_rst_i ? run_ff + 8'h01 : 8'h00;
      if (dog_rst_i && run_ff == 8'h00) begin
        rst_cnt_o <= rst_cnt_o + 8'h01;
      end
      if (!dog_rst_i && run_ff != 8'h00) begin
        rst_len_o <= run_ff;
      end
    end
  end
endmodule // wdm_core_model

//--- testbench/watchdog_timer_monitor_tb_top.sv
// Purpose: register-level regression of the watchdog timer monitor
// Assumes: short divider taps 8..11 so time-outs stay brief but clear the early tests
// Notes: bus results taken at the rising edge where waitrequest is sampled low
`timescale 1ns/100ps
module watchdog_timer_monitor_tb_top;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic we = 1'b0;
  logic [31:0] wd = 32'h0;
  logic ge = 1'b0;
  logic ta = 1'b0;
  logic [31:0] rdat;
  logic wq, irq, drst;
  logic [7:0] rcnt, rlen;
  logic [31:0] q;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  always #4 clk_i = ~clk_i;
  wdm_top #(.EXP0(8), .EXP1(9), .EXP2(10), .EXP3(11)) i_dut (.clk_i(clk_i), .srst_i(srst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(we), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .global_irq_enable_i(ge), .ta_open_i(ta), .irq_o(irq), .dog_sys_rst_o(drst));
  wdm_core_model i_core (.clk_i(clk_i), .srst_i(srst_i), .dog_rst_i(drst), .rst_cnt_o(rcnt), .rst_len_o(rlen));
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic t);
    @(posedge clk_i);
    adr <= a;
    rd <= !w;
    we <= w;
    wd <= {24'h0, d};
    ta <= t;
    do @(posedge clk_i); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    we <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 10000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 0); chk(q, 32'h0);
    bus(0, wdm_pkg::ADDR_CKCTL, 8'h00, 0); chk(q, 32'h0);
    bus(0, 4'hC, 8'h00, 0); chk(q, 32'h0);
    bus(1, wdm_pkg::ADDR_WDCTL, 8'h08, 0);
    bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 0); chk(q, 32'h0);
    bus(1, wdm_pkg::ADDR_WDCTL, 8'h08, 1);
    bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 1); chk(q, 32'h08);
    bus(1, wdm_pkg::ADDR_EIE, 8'h10, 1);
    ge <= 1'b1;
    @(negedge clk_i); chk(irq, 1'b1);
    @(posedge clk_i) ge <= 1'b0;
    @(negedge clk_i); chk(irq, 1'b0);
    for (int s = 0; s < 4; s++) begin
      bus(1, wdm_pkg::ADDR_CKCTL, 8'(s << 6), 1);
      // restart first so the count starts from a known point
      bus(1, wdm_pkg::ADDR_WDCTL, 8'h01, 1);
      repeat ((1 << (8 + s)) - 8) @(posedge clk_i);
      bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 1); chk(q, 32'h0);
      repeat (12) @(posedge clk_i);
      bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 1); chk(q, 32'h08);
    end
    bus(1, wdm_pkg::ADDR_CKCTL, 8'h00, 1);
    bus(1, wdm_pkg::ADDR_WDCTL, 8'h03, 1);
    n = 0;
    while (rcnt !== 8'h01 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk(n >= 760 && n <= 790, 1'b1);
    repeat (20) @(posedge clk_i);
    chk(rlen, 8'(wdm_pkg::RST_CYCLES));
    bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 1); chk(q, 32'h06);
    bus(1, wdm_pkg::ADDR_WDCTL, 8'h03, 1);
    repeat (200) @(posedge clk_i);
    bus(1, wdm_pkg::ADDR_WDCTL, 8'h03, 1);
    repeat (400) @(posedge clk_i);
    chk(rcnt, 8'h01);
    bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 1); chk(q, 32'h0A);
    bus(1, wdm_pkg::ADDR_WDCTL, 8'h00, 1);
    repeat (700) @(posedge clk_i);
    chk(rcnt, 8'h01);
    bus(0, wdm_pkg::ADDR_WDCTL, 8'h00, 1); chk(q, 32'h08);
    final_report();
  end
endmodule // watchdog_timer_monitor_tb_top
